// ---- core/rss_top.sv ----
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "rss_map.svh"
module rss_top (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire rss_pkg::rss_bus_req_t bus_i,
	input wire rss_pkg::rss_buf_evt_t buf_evt_i,
	input wire rss_pkg::rss_lock_t lock_i,
	output logic [7:0] rdata_o,
	output logic drop_frame_o,
	output logic replay_frame_o,
	output logic irq_o
);
	import rss_pkg::*;

	//----------------------------------------
	// Slip detection and lock sampling
	//----------------------------------------
	logic ovf_pulse, unf_pulse;
	rss_lock_t lock_q;

	rss_slip_ctl u_slip (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.evt_i(buf_evt_i),
		.drop_frame_o(drop_frame_o),
		.replay_frame_o(replay_frame_o),
		.ovf_pulse_o(ovf_pulse),
		.unf_pulse_o(unf_pulse)
	);

	rss_sync_stat u_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.lock_i(lock_i),
		.lock_o(lock_q)
	);

	//----------------------------------------
	// Register file
	//----------------------------------------
	logic [2:0] stat_reg, stat_next;
	logic [7:0] enable_reg, enable_next;
	logic [7:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic [2:0] set_vec;
	logic stat_rd;
	logic en_rd;
	logic en_wr;

	// Exact match: the port has no byte lanes and no mirrored addresses
	function automatic logic hit(input logic [15:0] a, input logic [15:0] offs);
		hit = (a == offs);
	endfunction

	// Places the slip pulses on their status positions
	function automatic logic [2:0] slip_bits(input logic ovf, input logic unf);
		slip_bits = 3'h0;
		slip_bits[`RSS_BIT_OVERFLOW] = ovf;
		slip_bits[`RSS_BIT_UNDERFLOW] = unf;
		slip_bits[`RSS_BIT_ANY_SLIP] = ovf | unf;
	endfunction

	//----------------------------------------
	// Address decode
	//----------------------------------------
	// A write to the status address decodes to nothing: its bits only clear by reading
	always_comb begin
		stat_rd = bus_i.rd && hit(bus_i.addr, `RSS_STATUS_OFFS);
		en_rd = bus_i.rd && hit(bus_i.addr, `RSS_ENABLE_OFFS);
		en_wr = bus_i.wr && hit(bus_i.addr, `RSS_ENABLE_OFFS);
	end

	//----------------------------------------
	// Slip status
	//----------------------------------------
	always_comb begin
		set_vec = slip_bits(ovf_pulse, unf_pulse);
		// Clear on read, but a slip landing in the read cycle survives
		stat_next = (stat_rd ? 3'h0 : stat_reg) | set_vec;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			stat_reg <= 3'(`RSS_STATUS_RST);
		end else begin
			stat_reg <= stat_next;
		end
	end

	//----------------------------------------
	// Interrupt enables
	//----------------------------------------
	always_comb begin
		enable_next = enable_reg;
		if (en_wr) begin
			// Only the three receive enables are stored; the rest read back zero
			enable_next = bus_i.wdata & `RSS_ENABLE_WMASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			enable_reg <= `RSS_ENABLE_RST;
		end else begin
			enable_reg <= enable_next;
		end
	end

	//----------------------------------------
	// Read-back
	//----------------------------------------
	// Data stand for one cycle only; an idle or unmapped read returns zero
	always_comb begin
		rdata_next = 8'h00;
		if (stat_rd) begin
			rdata_next[2:0] = stat_reg;
			rdata_next[`RSS_BIT_MF_LOCK] = lock_q.mf_lock;
			rdata_next[`RSS_BIT_SF_SYNC] = lock_q.sf_sync;
		end else if (en_rd) begin
			rdata_next = enable_reg;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	//----------------------------------------
	// Interrupt line
	//----------------------------------------
	// Built from next-state values so the line moves on the edge that sets the bit
	always_comb begin
		irq_next = |(stat_next & enable_next[2:0]);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	//----------------------------------------
	// Outputs
	//----------------------------------------
	assign rdata_o = rdata_reg;
	assign irq_o = irq_reg;

	//----------------------------------------
	// Checks
	//----------------------------------------
	// Latching of slip events
	ovf_sets_bit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		ovf_pulse |=> stat_reg[2] && stat_reg[0])
		else $error("overflow not latched");

	unf_sets_bit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		unf_pulse |=> stat_reg[1] && stat_reg[0])
		else $error("underflow not latched");

	any_slip_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(stat_reg[2] | stat_reg[1]) |-> stat_reg[0])
		else $error("combined slip missing");

	any_slip_sum_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_reg[0] == (stat_reg[2] || stat_reg[1]))
		else $error("combined slip out of step");

	slip_cause_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(stat_reg[0]) |-> $past(ovf_pulse || unf_pulse))
		else $error("slip bit set without event");

	ovf_wins_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_rd && ovf_pulse && !unf_pulse |=> stat_reg == 3'b101)
		else $error("overflow lost to read clear");

	unf_wins_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_rd && unf_pulse && !ovf_pulse |=> stat_reg == 3'b011)
		else $error("underflow lost to read clear");

	// Hold until read, then return and clear
	read_clears_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_rd && !ovf_pulse && !unf_pulse |=> stat_reg == 3'h0 && rdata_o[2:0] == $past(stat_reg))
		else $error("read did not return then clear");

	read_returns_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_rd |=> rdata_o[2:0] == $past(stat_reg))
		else $error("read lost latched bits");

	hold_set_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_reg[0] && !stat_rd |=> stat_reg[0])
		else $error("slip bit dropped early");

	ovf_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_reg[2] && !stat_rd |=> stat_reg[2])
		else $error("overflow bit dropped early");

	unf_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_reg[1] && !stat_rd |=> stat_reg[1])
		else $error("underflow bit dropped early");

	stat_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!stat_rd && !ovf_pulse && !unf_pulse |=> $stable(stat_reg))
		else $error("status moved without cause");

	stat_wr_ignored_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		bus_i.wr && hit(bus_i.addr, `RSS_STATUS_OFFS) && !ovf_pulse && !unf_pulse |=> $stable(stat_reg))
		else $error("status took a write");

	// Frame actions
	drop_only_full_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!buf_evt_i.wr_full |=> !drop_frame_o)
		else $error("frame dropped without full write");

	replay_only_empty_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!buf_evt_i.rd_empty |=> !replay_frame_o)
		else $error("frame replayed without empty read");

	// Lock levels and read data
	lock_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_rd |=> rdata_o[4:3] == $past({lock_q.sf_sync, lock_q.mf_lock}))
		else $error("lock bits wrong");

	sf_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_rd |=> rdata_o[`RSS_BIT_SF_SYNC] == $past(lock_q.sf_sync))
		else $error("sync bit wrong");

	mf_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_rd |=> rdata_o[`RSS_BIT_MF_LOCK] == $past(lock_q.mf_lock))
		else $error("multiframe lock bit wrong");

	stat_top_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		stat_rd |=> rdata_o[7:5] == 3'h0)
		else $error("absent status bits not zero");

	rdata_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!bus_i.rd |=> rdata_o == 8'h00)
		else $error("read data outside read");

	unmapped_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		bus_i.rd && !stat_rd && !en_rd |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");

	// Enables and the interrupt line
	en_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		en_wr |=> enable_reg == ($past(bus_i.wdata) & `RSS_ENABLE_WMASK))
		else $error("enable write lost");

	en_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!en_wr |=> $stable(enable_reg))
		else $error("enable moved without write");

	en_upper_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		enable_reg[7:3] == 5'h00)
		else $error("absent enable bits set");

	en_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		en_rd |=> rdata_o == $past(enable_reg))
		else $error("enable read wrong");

	irq_level_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		##1 irq_o == |(stat_reg & enable_reg[2:0]))
		else $error("interrupt mismatch");

	irq_masked_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		enable_reg[2:0] == 3'h0 |-> !irq_o)
		else $error("interrupt while all masked");

	irq_pending_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		(stat_reg & enable_reg[2:0]) != 3'h0 |-> irq_o)
		else $error("enabled slip without interrupt");

	ovf_raises_irq_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		ovf_pulse && !en_wr && enable_reg[2] |=> irq_o)
		else $error("overflow did not interrupt");

	unf_raises_irq_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		unf_pulse && !en_wr && enable_reg[1] |=> irq_o)
		else $error("underflow did not interrupt");

	irq_rise_cause_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(irq_o) |-> $past(ovf_pulse || unf_pulse || en_wr))
		else $error("interrupt rose without cause");

	irq_fall_cause_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$fell(irq_o) && $past(rstn_i) |-> $past(stat_rd || en_wr))
		else $error("interrupt fell without cause");
endmodule

// ---- core/rss_map.svh ----
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// Register offsets (byte-free index space of the register port)
`define RSS_STATUS_OFFS 16'h0b08
`define RSS_ENABLE_OFFS 16'h0b09

// Status field positions
`define RSS_BIT_ANY_SLIP 0
`define RSS_BIT_UNDERFLOW 1
`define RSS_BIT_OVERFLOW 2
`define RSS_BIT_MF_LOCK 3
`define RSS_BIT_SF_SYNC 4

// Reset values and the enable write mask
`define RSS_STATUS_RST 8'h00
`define RSS_ENABLE_RST 8'h00
`define RSS_ENABLE_WMASK 8'h07

`endif

// ---- core/rss_pkg.sv ----
package rss_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rss_bus_req_t;

	typedef struct packed {
		logic wr_full;
		logic rd_empty;
	} rss_buf_evt_t;

	typedef struct packed {
		logic sf_sync;
		logic mf_lock;
	} rss_lock_t;

	typedef enum logic [1:0] {
		RSS_IDLE = 2'b00,
		RSS_DROP = 2'b01,
		RSS_REPLAY = 2'b10
	} rss_slip_st_t;
endpackage

// ---- core/rss_slip_ctl.sv ----
`timescale 1ns/100ps
// Turns buffer access collisions into slip actions and slip events, each registered one cycle after its collision and as long as it.
module rss_slip_ctl (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire rss_pkg::rss_buf_evt_t evt_i,
	output logic drop_frame_o,
	output logic replay_frame_o,
	output logic ovf_pulse_o,
	output logic unf_pulse_o
);
	import rss_pkg::*;

	logic drop_reg, drop_next;
	logic replay_reg, replay_next;

	always_comb begin
		drop_next = evt_i.wr_full;
		replay_next = evt_i.rd_empty;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			drop_reg <= 1'b0;
			replay_reg <= 1'b0;
		end else begin
			drop_reg <= drop_next;
			replay_reg <= replay_next;
		end
	end

	// Write into a full buffer discards a whole frame
	assign drop_frame_o = drop_reg;
	// Read from an empty buffer repeats a whole frame
	assign replay_frame_o = replay_reg;
	assign ovf_pulse_o = drop_reg;
	assign unf_pulse_o = replay_reg;

	drop_after_full_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		evt_i.wr_full |=> drop_frame_o && ovf_pulse_o) else $error("full write did not drop frame");
	replay_after_empty_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		evt_i.rd_empty |=> replay_frame_o && unf_pulse_o) else $error("empty read did not replay");
endmodule

// ---- core/rss_sync_stat.sv ----
`timescale 1ns/100ps
`include "rss_map.svh"
// Registers the two framer lock levels for read-back.
module rss_sync_stat (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire rss_pkg::rss_lock_t lock_i,
	output rss_pkg::rss_lock_t lock_o
);
	import rss_pkg::*;

	rss_lock_t lock_reg, lock_next;

	always_comb begin
		lock_next = lock_i;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			lock_reg <= '0;
		end else begin
			lock_reg <= lock_next;
		end
	end

	assign lock_o = lock_reg;

	sf_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		1'b1 |=> lock_o.sf_sync == $past(lock_i.sf_sync)) else $error("sync bit lags");
	mf_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		1'b1 |=> lock_o.mf_lock == $past(lock_i.mf_lock)) else $error("lock bit lags");
endmodule

// ---- dv/rss_top_tb.sv ----
`timescale 1ns/100ps
`include "rss_map.svh"
module rss_top_tb;
	import rss_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	rss_bus_req_t bus_i = '0;
	rss_buf_evt_t buf_evt_i = '0;
	rss_lock_t lock_i = '0;
	logic [7:0] rdata_o;
	logic drop_frame_o;
	logic replay_frame_o;
	logic irq_o;
	int failures = 0;
	int n_compared = 0;
	int gap = 0;
	logic [2:0] m_stat;
	logic [2:0] m_en;
	logic [7:0] m_rdata;
	logic m_drop;
	logic m_rep;
	logic m_irq;
	rss_lock_t m_lock;
	logic m_on = 1'b0;

	always #5 clk_sys_i = ~clk_sys_i;

	rss_top rss_top_inst (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.bus_i(bus_i),
		.buf_evt_i(buf_evt_i),
		.lock_i(lock_i),
		.rdata_o(rdata_o),
		.drop_frame_o(drop_frame_o),
		.replay_frame_o(replay_frame_o),
		.irq_o(irq_o)
	);

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	// Set wins over read-clear, so clear first and then merge new events
	always @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			{m_stat, m_en, m_rdata, m_drop, m_rep, m_irq} = '0;
			m_lock = '0;
			m_on = 1'b1;
		end else begin
			m_rdata = 8'h00;
			if (bus_i.rd && bus_i.addr == `RSS_ENABLE_OFFS) m_rdata = {5'h00, m_en};
			if (bus_i.rd && bus_i.addr == `RSS_STATUS_OFFS) begin
				m_rdata = {3'h0, m_lock.sf_sync, m_lock.mf_lock, m_stat};
				m_stat = 3'h0;
			end
			// Status takes the registered slip pulse, a cycle after the buffer event
			m_stat = m_stat | {m_drop, m_rep, m_drop | m_rep};
			if (bus_i.wr && bus_i.addr == `RSS_ENABLE_OFFS) m_en = bus_i.wdata[2:0];
			m_drop = buf_evt_i.wr_full;
			m_rep = buf_evt_i.rd_empty;
			m_lock = lock_i;
			m_irq = |(m_stat & m_en);
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	always @(negedge clk_sys_i) begin
		if (m_on) begin
			check(rdata_o, m_rdata);
			check({7'h00, drop_frame_o}, {7'h00, m_drop});
			check({7'h00, replay_frame_o}, {7'h00, m_rep});
			check({7'h00, irq_o}, {7'h00, m_irq});
		end
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	// Slip events are spaced so the slip controller is never asked twice in a row
	task automatic cycle(input bit rd_ok);
		int r;
		int e;
		@(posedge clk_sys_i);
		r = $urandom_range(0, 5);
		e = (gap > 1) ? $urandom_range(0, 4) : 4;
		gap = (e < 2) ? 0 : gap + 1;
		bus_i.addr <= 16'h0b08 + 16'($urandom_range(0, 2));
		bus_i.wdata <= 8'($urandom);
		bus_i.wr <= (r == 1 || r == 2);
		bus_i.rd <= rd_ok && (r >= 3);
		buf_evt_i.wr_full <= (e == 0);
		buf_evt_i.rd_empty <= (e == 1);
	endtask

	task automatic tally_and_finish();
		$display("compared=%0d mismatches=%0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(76557));
		repeat (4) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		for (int seg = 0; seg < 8; seg++) begin
			// Lock levels held still around reads because they are registered once
			@(posedge clk_sys_i);
			lock_i <= 2'($urandom);
			bus_i.wr <= 1'b0;
			bus_i.rd <= 1'b0;
			buf_evt_i <= '0;
			repeat (3) cycle(1'b0);
			repeat (60) cycle(1'b1);
			$display("test random segment %0d done", seg);
		end
		@(posedge clk_sys_i);
		rstn_i <= 1'b0;
		bus_i.wr <= 1'b0;
		bus_i.rd <= 1'b0;
		buf_evt_i <= '0;
		@(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (60) cycle(1'b1);
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
